/* pxop_cmd_dec.sv */
/*
 * Pixel operation command decoder: holds the write-only control word,
 * decodes it and launches coprocessor operations.
 * Assumes the register port is synchronous to i_clock and that the engine
 * reports completion with a one-cycle pulse on i_op_done.
 */
`timescale 1ns/100ps
`include "pxop_map.svh"

// Summary of operation
// - Write-only 32-bit control register at 7C
// - Top byte write starts non draw-step operations
// - Contents frozen while operation runs
// - Byte layout independent of host ordering
// - Bits 31-30 select background source
// - Bits 29-28 select foreground source
// - Bits 27-24 are the function code
// - Draw-step starts on direction steps write
// - Bits 23-20 select source map
// - Bits 19-16 select destination map
// - Bits 15-12 select pattern source
// - Fixed pattern forces foreground on all
// - Source-derived pattern: nonzero means foreground
// - Bits 7-6 select mask mode
// - Bits 5-4 select drawing attributes
// - Low three bits give direction octant
module pxop_cmd_dec #(
    parameter int PIX_W = 8 // Source pixel width
) (
    input wire logic i_clock, // 10 MHz clock
    input wire logic i_nrst, // Async reset, low
    input wire logic i_wr_en, // Register write strobe
    input wire logic [`PXOP_ADDR_W-1:0] i_wr_addr, // Word byte address
    input wire logic [3:0] i_wr_be, // Byte enables
    input wire logic [31:0] i_wr_data, // Write data
    input wire logic i_op_done, // Engine finished pulse
    input wire logic i_pat_map_bit, // Pattern map bit
    input wire logic [PIX_W-1:0] i_src_pixel, // Current source pixel
    output logic o_op_start, // Launch pulse
    output logic o_busy, // Operation running
    output logic o_wr_refused, // Write lost while busy
    output pxop_pkg::pxop_func_t o_func, // Latched function
    output logic o_func_rsvd, // Function code reserved
    output pxop_pkg::pxop_src_t o_bg_src, // Background source
    output pxop_pkg::pxop_src_t o_fg_src, // Foreground source
    output pxop_pkg::pxop_map_t o_src_map, // Source map
    output pxop_pkg::pxop_map_t o_dst_map, // Destination map
    output pxop_pkg::pxop_map_t o_pat_map, // Pattern selection
    output logic [1:0] o_mask_mode, // Mask mode
    output logic o_mask_rsvd, // Mask code reserved
    output logic [1:0] o_draw_attr_mode, // Drawing attributes
    output logic o_axis_select_flag, // Octant axis bit
    output logic o_vertical_sign_bit, // Octant vertical bit
    output logic o_horizontal_sign_bit, // Octant horizontal bit
    output logic o_pattern_bit, // Resolved pattern pixel
    output logic o_use_foreground // Foreground mix select
);
    import pxop_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (PIX_W < 1 || PIX_W > 32) begin : g_bad_width
        $error("pxop_cmd_dec: PIX_W out of range");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True for the two draw-and-step codes
    function automatic logic is_draw_step(input logic [3:0] code);
        is_draw_step = (code == PXOP_FN_DS_READ) || (code == PXOP_FN_DS_WRITE);
    endfunction : is_draw_step

    // True for any assigned function code
    function automatic logic is_valid_fn(input logic [3:0] code);
        unique case (code)
            PXOP_FN_DS_READ, PXOP_FN_LD_READ, PXOP_FN_DS_WRITE, PXOP_FN_LD_WRITE,
            PXOP_FN_BLT, PXOP_FN_BLT_INV, PXOP_FN_BLT_FILL: is_valid_fn = 1'b1;
            default: is_valid_fn = 1'b0;
        endcase
    endfunction : is_valid_fn

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    pxop_state_t state_reg;
    pxop_state_t state_next;
    logic start_reg;
    logic refused_reg;
    pxop_func_t func_reg;
    logic func_rsvd_reg;
    logic ctrl_hit;
    logic steps_hit;
    logic top_byte_wr;
    logic launch;
    logic [3:0] new_fn;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Lane n always maps to bits 8n+7..8n, whatever the host ordering
    assign ctrl_hit = i_wr_en && (i_wr_addr == `PXOP_OFF_CONTROL);
    assign steps_hit = i_wr_en && (i_wr_addr == `PXOP_OFF_DIR_STEPS);
    assign top_byte_wr = ctrl_hit && i_wr_be[3];

    // Byte-merged next value; lower lanes may arrive first
    always_comb begin
        ctrl_next = ctrl_reg;
        for (int b = 0; b < 4; b++) begin
            if (ctrl_hit && i_wr_be[b]) begin
                ctrl_next[8*b +: 8] = i_wr_data[8*b +: 8];
            end
        end
    end

    assign new_fn = ctrl_next[`PXOP_FN_HI:`PXOP_FN_LO];

    // Launch: top byte for most codes, direction steps for draw-step
    always_comb begin
        launch = 1'b0;
        if (state_reg == PXOP_IDLE) begin
            if (top_byte_wr && !is_draw_step(new_fn)) begin
                launch = 1'b1;
            end else if (steps_hit && is_draw_step(new_fn)) begin
                launch = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control word storage
    // ------------------------------------------------------------------
    // No read path exists; writes during a run are dropped so the engine
    // sees one stable word from start to finish
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= `PXOP_CTRL_RESET;
        end else if (state_reg == PXOP_IDLE) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------------
    // Operation tracking
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PXOP_IDLE: if (launch) state_next = PXOP_BUSY;
            PXOP_BUSY: if (i_op_done) state_next = PXOP_IDLE;
            default: state_next = PXOP_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= PXOP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Start pulse and latched function code
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            start_reg <= 1'b0;
            func_reg <= PXOP_FN_BLT;
            func_rsvd_reg <= 1'b0;
        end else begin
            start_reg <= launch;
            if (launch) begin
                func_reg <= pxop_func_t'(new_fn);
                func_rsvd_reg <= !is_valid_fn(new_fn);
            end
        end
    end

    // One-cycle flag when a control write hits a running operation
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= ctrl_hit && (state_reg == PXOP_BUSY);
        end
    end

    assign o_op_start = start_reg;
    assign o_busy = (state_reg == PXOP_BUSY);
    assign o_wr_refused = refused_reg;
    assign o_func = func_reg;
    assign o_func_rsvd = func_rsvd_reg;

    // ------------------------------------------------------------------
    // Field decode and pattern resolution
    // ------------------------------------------------------------------
    pxop_field_dec u_fields (
        .i_word(ctrl_reg),
        .o_bg_src(o_bg_src),
        .o_fg_src(o_fg_src),
        .o_src_map(o_src_map),
        .o_dst_map(o_dst_map),
        .o_pat_map(o_pat_map),
        .o_mask_mode(o_mask_mode),
        .o_mask_rsvd(o_mask_rsvd),
        .o_draw_attr_mode(o_draw_attr_mode),
        .o_axis_select_flag(o_axis_select_flag),
        .o_vertical_sign_bit(o_vertical_sign_bit),
        .o_horizontal_sign_bit(o_horizontal_sign_bit)
    );

    pxop_pattern #(
        .PIX_W(PIX_W)
    ) u_pattern (
        .i_pat_map(o_pat_map),
        .i_pat_map_bit(i_pat_map_bit),
        .i_src_pixel(i_src_pixel),
        .o_pattern_bit(o_pattern_bit),
        .o_use_foreground(o_use_foreground)
    );

endmodule : pxop_cmd_dec

/* pxop_cmd_dec_sva.sv */
/*
 * Checker for the command decoder, bound to its top module.
 * Assumes a single clock domain and the asynchronous low reset.
 */
`timescale 1ns/100ps
`include "pxop_map.svh"

module pxop_cmd_dec_sva #(
    parameter int PIX_W = 8 // Source pixel width
) (
    input wire logic i_clock, // Clock
    input wire logic i_nrst, // Reset, low
    input wire logic i_wr_en, // Write strobe
    input wire logic [`PXOP_ADDR_W-1:0] i_wr_addr, // Address
    input wire logic [3:0] i_wr_be, // Byte enables
    input wire logic [31:0] i_wr_data, // Write data
    input wire logic i_op_done, // Engine done
    input wire logic [PIX_W-1:0] i_src_pixel, // Source pixel
    input wire logic o_op_start, // Launch pulse
    input wire logic o_busy, // Running
    input wire logic o_wr_refused, // Dropped write
    input pxop_pkg::pxop_func_t o_func, // Function
    input pxop_pkg::pxop_src_t o_bg_src, // Background source
    input pxop_pkg::pxop_src_t o_fg_src, // Foreground source
    input pxop_pkg::pxop_map_t o_src_map, // Source map
    input pxop_pkg::pxop_map_t o_dst_map, // Destination map
    input pxop_pkg::pxop_map_t o_pat_map, // Pattern selection
    input wire logic [1:0] o_mask_mode, // Mask mode
    input wire logic [1:0] o_draw_attr_mode, // Drawing attributes
    input wire logic o_axis_select_flag, // Octant bit 0
    input wire logic o_vertical_sign_bit, // Octant bit 1
    input wire logic o_horizontal_sign_bit, // Octant bit 2
    input wire logic o_pattern_bit, // Pattern pixel
    input wire logic o_use_foreground // Foreground mix
);
    import pxop_pkg::*;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // Control write that the idle decoder must accept
    logic ctl_wr;
    assign ctl_wr = i_wr_en && (i_wr_addr == `PXOP_OFF_CONTROL) && !o_busy;

    function automatic pxop_map_t dst_dec(input logic [31:0] w);
        return (w[19:16] inside {4'h1, 4'h2, 4'h3}) ? pxop_map_t'(w[18:16]) : PXOP_SEL_NONE;
    endfunction : dst_dec

    function automatic pxop_src_t bg_dec(input logic [31:0] w);
        return (w[31:30] == 2'h0) ? PXOP_SRC_COLOR : (w[31:30] == 2'h2) ? PXOP_SRC_MAP : PXOP_SRC_RSVD;
    endfunction : bg_dec

    // --------------------------------------------------------------
    // Launch, hold and completion
    // --------------------------------------------------------------
    property p_launch;
        ctl_wr && i_wr_be[3] && !(i_wr_data[27:24] inside {4'h2, 4'h4}) |=> o_op_start && o_busy;
    endproperty
    a_launch: assert property (p_launch) else $error("top byte write did not launch");

    property p_no_launch;
        ctl_wr && (!i_wr_be[3] || (i_wr_data[27:24] inside {4'h2, 4'h4})) |=> !o_op_start;
    endproperty
    a_no_launch: assert property (p_no_launch) else $error("launch without top byte");

    property p_pulse;
        o_op_start |=> !o_op_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("launch pulse too long");

    property p_frozen;
        o_busy && $past(o_busy) |-> $stable({o_bg_src, o_fg_src, o_src_map, o_dst_map, o_pat_map,
            o_mask_mode, o_draw_attr_mode, o_horizontal_sign_bit, o_vertical_sign_bit, o_axis_select_flag});
    endproperty
    a_frozen: assert property (p_frozen) else $error("fields changed while busy");

    property p_refuse;
        i_wr_en && (i_wr_addr == `PXOP_OFF_CONTROL) && o_busy && !i_op_done |=> o_wr_refused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("busy write not refused");

    property p_busy_end;
        o_busy |=> o_busy != $past(i_op_done);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy not ended by done");

    // --------------------------------------------------------------
    // Field decoding
    // --------------------------------------------------------------
    property p_dst;
        ctl_wr && i_wr_be[2] |=> o_dst_map == dst_dec($past(i_wr_data));
    endproperty
    a_dst: assert property (p_dst) else $error("destination map wrong");

    property p_bg;
        ctl_wr && i_wr_be[3] |=> o_bg_src == bg_dec($past(i_wr_data));
    endproperty
    a_bg: assert property (p_bg) else $error("background source wrong");

    property p_low;
        ctl_wr && i_wr_be[0] |=> {26'h0, o_draw_attr_mode, 1'b0, o_horizontal_sign_bit,
            o_vertical_sign_bit, o_axis_select_flag} == ($past(i_wr_data) & 32'h00000037);
    endproperty
    a_low: assert property (p_low) else $error("octant or draw mode wrong");

    property p_fixed;
        o_pat_map == PXOP_SEL_FIXED |-> o_pattern_bit && o_use_foreground;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed pattern not foreground");

    property p_from_src;
        o_pat_map == PXOP_SEL_FROM_SRC |-> o_pattern_bit == (|i_src_pixel) && o_use_foreground == o_pattern_bit;
    endproperty
    a_from_src: assert property (p_from_src) else $error("source pattern wrong");

    c_blt: cover property (o_op_start && o_func == PXOP_FN_BLT);
    c_ds: cover property (o_op_start && o_func == PXOP_FN_DS_WRITE);
    c_refused: cover property (o_wr_refused);
    c_fixed: cover property (o_busy && o_pat_map == PXOP_SEL_FIXED);
endmodule : pxop_cmd_dec_sva

bind pxop_cmd_dec pxop_cmd_dec_sva #(.PIX_W(PIX_W)) pxop_cmd_dec_sva_inst (.*);

/* pxop_field_dec.sv */
/*
 * Decodes a held control word into operation fields.
 * Assumes the word is stable while an operation runs.
 */
`timescale 1ns/100ps
`include "pxop_map.svh"

module pxop_field_dec (
    input wire logic [31:0] i_word, // Held control word
    output pxop_pkg::pxop_src_t o_bg_src, // Background source
    output pxop_pkg::pxop_src_t o_fg_src, // Foreground source
    output pxop_pkg::pxop_map_t o_src_map, // Source map
    output pxop_pkg::pxop_map_t o_dst_map, // Destination map
    output pxop_pkg::pxop_map_t o_pat_map, // Pattern selection
    output logic [1:0] o_mask_mode, // Mask mode, 11 flagged
    output logic o_mask_rsvd, // Mask code reserved
    output logic [1:0] o_draw_attr_mode, // Drawing attributes
    output logic o_axis_select_flag, // Octant axis bit
    output logic o_vertical_sign_bit, // Octant vertical bit
    output logic o_horizontal_sign_bit // Octant horizontal bit
);
    import pxop_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic pxop_src_t src_dec(input logic [1:0] code);
        unique case (code)
            `PXOP_COLOR_SEL: src_dec = PXOP_SRC_COLOR;
            `PXOP_MAP_SEL: src_dec = PXOP_SRC_MAP;
            default: src_dec = PXOP_SRC_RSVD;
        endcase
    endfunction : src_dec

    function automatic pxop_map_t map_dec(input logic [3:0] code);
        unique case (code)
            `PXOP_MAP_A: map_dec = PXOP_SEL_A;
            `PXOP_MAP_B: map_dec = PXOP_SEL_B;
            `PXOP_MAP_C: map_dec = PXOP_SEL_C;
            default: map_dec = PXOP_SEL_NONE;
        endcase
    endfunction : map_dec

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // Bits 11..8 and 3 are never looked at
    assign o_bg_src = src_dec(i_word[`PXOP_BG_HI:`PXOP_BG_LO]);
    assign o_fg_src = src_dec(i_word[`PXOP_FG_HI:`PXOP_FG_LO]);
    assign o_src_map = map_dec(i_word[`PXOP_SRC_HI:`PXOP_SRC_LO]);
    assign o_dst_map = map_dec(i_word[`PXOP_DST_HI:`PXOP_DST_LO]);

    // Pattern adds the fixed and source-derived codes to the map codes
    always_comb begin
        unique case (i_word[`PXOP_PAT_HI:`PXOP_PAT_LO])
            `PXOP_PAT_FIXED: o_pat_map = PXOP_SEL_FIXED;
            `PXOP_PAT_FROM_SRC: o_pat_map = PXOP_SEL_FROM_SRC;
            default: o_pat_map = map_dec(i_word[`PXOP_PAT_HI:`PXOP_PAT_LO]);
        endcase
    end

    assign o_mask_mode = i_word[`PXOP_MSK_HI:`PXOP_MSK_LO];
    assign o_mask_rsvd = &i_word[`PXOP_MSK_HI:`PXOP_MSK_LO];
    assign o_draw_attr_mode = i_word[`PXOP_DRW_HI:`PXOP_DRW_LO];
    assign o_axis_select_flag = i_word[`PXOP_AXIS_BIT];
    assign o_vertical_sign_bit = i_word[`PXOP_VERT_BIT];
    assign o_horizontal_sign_bit = i_word[`PXOP_HORZ_BIT];

endmodule : pxop_field_dec

/* pxop_host_model.sv */
/*
 * Host model: issues register writes to the command decoder.
 * Assumes the bench calls its tasks in sequence, never two at once.
 */
`timescale 1ns/100ps
`include "pxop_map.svh"

module pxop_host_model (
    input wire logic i_clock, // Bus clock
    output logic o_wr_en, // Write strobe
    output logic [`PXOP_ADDR_W-1:0] o_wr_addr, // Byte address
    output logic [3:0] o_wr_be, // Byte enables
    output logic [31:0] o_wr_data // Write data
);
    // Idle bus; released lines show the inverse so stale data never looks valid
    initial begin
        o_wr_en = 1'b0;
        o_wr_addr = 7'h00;
        o_wr_be = 4'h0;
        o_wr_data = 32'h00000000;
    end

    // One write: held for exactly one sampling edge
    task automatic wr(input logic [6:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clock);
        #1;
        o_wr_en = 1'b1;
        o_wr_addr = a;
        o_wr_be = be;
        o_wr_data = d;
        @(posedge i_clock);
        #1;
        o_wr_en = 1'b0;
        o_wr_addr = ~a;
        o_wr_be = ~be;
        o_wr_data = ~d;
    endtask : wr

    // Whole word, two halves or four bytes; the top byte always goes last
    task automatic load(input logic [31:0] d, input int mode);
        int r;
        r = $urandom % 3;
        if (mode == 0) begin
            wr(`PXOP_OFF_CONTROL, 4'hF, d);
        end else if (mode == 1) begin
            wr(`PXOP_OFF_CONTROL, 4'h3, d);
            wr(`PXOP_OFF_CONTROL, 4'hC, d);
        end else begin
            for (int k = 0; k < 3; k++) begin
                wr(`PXOP_OFF_CONTROL, 4'(4'h1 << ((k + r) % 3)), d);
            end
            wr(`PXOP_OFF_CONTROL, 4'h8, d);
        end
    endtask : load
endmodule : pxop_host_model

/* pxop_map.svh */
/*
 * Offsets, field positions, codes and reset values of the pixel operation
 * command decoder. Definitions only; included by the package and modules.
 */
`ifndef PXOP_MAP_SVH
`define PXOP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses in the coprocessor register bank)
// ----------------------------------------------------------------------
`define PXOP_OFF_CONTROL 7'h7C
`define PXOP_OFF_DIR_STEPS 7'h2C
`define PXOP_ADDR_W 7

// ----------------------------------------------------------------------
// Field positions of the control register
// ----------------------------------------------------------------------
`define PXOP_BG_HI 31
`define PXOP_BG_LO 30
`define PXOP_FG_HI 29
`define PXOP_FG_LO 28
`define PXOP_FN_HI 27
`define PXOP_FN_LO 24
`define PXOP_SRC_HI 23
`define PXOP_SRC_LO 20
`define PXOP_DST_HI 19
`define PXOP_DST_LO 16
`define PXOP_PAT_HI 15
`define PXOP_PAT_LO 12
`define PXOP_MSK_HI 7
`define PXOP_MSK_LO 6
`define PXOP_DRW_HI 5
`define PXOP_DRW_LO 4
`define PXOP_AXIS_BIT 0
`define PXOP_VERT_BIT 1
`define PXOP_HORZ_BIT 2

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define PXOP_COLOR_SEL 2'h0
`define PXOP_MAP_SEL 2'h2
`define PXOP_MAP_A 4'h1
`define PXOP_MAP_B 4'h2
`define PXOP_MAP_C 4'h3
`define PXOP_PAT_FIXED 4'h8
`define PXOP_PAT_FROM_SRC 4'h9
`define PXOP_CTRL_RESET 32'h00000000

`endif

/* pxop_pattern.sv */
/*
 * Resolves the pattern bit of one pixel and the mix to use.
 * Assumes the caller supplies the pattern map bit and source pixel.
 */
`timescale 1ns/100ps

module pxop_pattern #(
    parameter int PIX_W = 8 // Source pixel width
) (
    input pxop_pkg::pxop_map_t i_pat_map, // Pattern selection
    input wire logic i_pat_map_bit, // Bit read from map
    input wire logic [PIX_W-1:0] i_src_pixel, // Source pixel
    output logic o_pattern_bit, // Pattern pixel
    output logic o_use_foreground // Foreground mix wanted
);
    import pxop_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (PIX_W < 1 || PIX_W > 32) begin : g_bad_width
        $error("pxop_pattern: PIX_W out of range");
    end

    // ------------------------------------------------------------------
    // Pattern selection
    // ------------------------------------------------------------------
    always_comb begin
        unique case (i_pat_map)
            PXOP_SEL_FIXED: o_pattern_bit = 1'b1;
            PXOP_SEL_FROM_SRC: o_pattern_bit = |i_src_pixel;
            default: o_pattern_bit = i_pat_map_bit;
        endcase
    end

    // Pattern 1 picks the foreground mix, 0 the background mix
    assign o_use_foreground = o_pattern_bit;

endmodule : pxop_pattern

/* pxop_pkg.sv */
/*
 * Types of the pixel operation command decoder.
 * Assumes pxop_map.svh is on the include path.
 */
`include "pxop_map.svh"

package pxop_pkg;

    // Function code of the control register
    typedef enum logic [3:0] {
        PXOP_FN_DS_READ = 4'h2,
        PXOP_FN_LD_READ = 4'h3,
        PXOP_FN_DS_WRITE = 4'h4,
        PXOP_FN_LD_WRITE = 4'h5,
        PXOP_FN_BLT = 4'h8,
        PXOP_FN_BLT_INV = 4'h9,
        PXOP_FN_BLT_FILL = 4'hA
    } pxop_func_t;

    // Colour or map source
    typedef enum logic [1:0] {
        PXOP_SRC_COLOR = 2'h0,
        PXOP_SRC_MAP = 2'h1,
        PXOP_SRC_RSVD = 2'h2
    } pxop_src_t;

    // Map selection result
    typedef enum logic [2:0] {
        PXOP_SEL_NONE = 3'h0,
        PXOP_SEL_A = 3'h1,
        PXOP_SEL_B = 3'h2,
        PXOP_SEL_C = 3'h3,
        PXOP_SEL_FIXED = 3'h4,
        PXOP_SEL_FROM_SRC = 3'h5
    } pxop_map_t;

    // Busy tracking states
    typedef enum logic [1:0] {
        PXOP_IDLE = 2'b01,
        PXOP_BUSY = 2'b10
    } pxop_state_t;

endpackage : pxop_pkg

/* tb_top.sv */
/*
 * Self-checking bench of the command decoder with a host model.
 * Assumes the engine is played here by pulsing i_op_done.
 */
`timescale 1ns/100ps
`include "pxop_map.svh"

module tb_top;
    import pxop_pkg::*;

    logic i_clock, i_nrst, i_op_done, i_pat_map_bit, i_wr_en;
    logic [7:0] i_src_pixel;
    logic [6:0] i_wr_addr;
    logic [3:0] i_wr_be;
    logic [31:0] i_wr_data, shadow;
    logic o_op_start, o_busy, o_wr_refused, o_func_rsvd, o_mask_rsvd;
    logic o_pattern_bit, o_use_foreground, o_axis_select_flag, o_vertical_sign_bit, o_horizontal_sign_bit;
    pxop_func_t o_func;
    pxop_src_t o_bg_src, o_fg_src;
    pxop_map_t o_src_map, o_dst_map, o_pat_map;
    logic [1:0] o_mask_mode, o_draw_attr_mode;
    logic [25:0] obs;
    logic [25:0] exp_q[$];
    int miscompares = 0;
    int n_checks = 0;

    assign obs = {o_func, o_func_rsvd, o_bg_src, o_fg_src, o_src_map, o_dst_map, o_pat_map,
                  o_mask_mode, o_mask_rsvd, o_draw_attr_mode,
                  o_horizontal_sign_bit, o_vertical_sign_bit, o_axis_select_flag};

    pxop_host_model pxop_host_model_inst (.i_clock(i_clock), .o_wr_en(i_wr_en), .o_wr_addr(i_wr_addr),
        .o_wr_be(i_wr_be), .o_wr_data(i_wr_data));

    pxop_cmd_dec pxop_cmd_dec_inst (.*);

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Counts: checks=%0d mismatches=%0d pending=%0d", n_checks, miscompares, exp_q.size());
        if (miscompares == 0 && n_checks > 0 && exp_q.size() == 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Expected decode, worked out independently of the design
    function automatic logic [1:0] sdec(input logic [1:0] c);
        return (c == 2'h0) ? 2'h0 : (c == 2'h2) ? 2'h1 : 2'h2;
    endfunction : sdec

    function automatic logic [2:0] mdec(input logic [3:0] c);
        return (c inside {4'h1, 4'h2, 4'h3}) ? c[2:0] : 3'h0;
    endfunction : mdec

    function automatic logic [25:0] dec(input logic [31:0] w);
        logic rsv;
        logic [2:0] pat;
        rsv = !(w[27:24] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA});
        pat = (w[15:12] == 4'h8) ? 3'h4 : (w[15:12] == 4'h9) ? 3'h5 : mdec(w[15:12]);
        return {w[27:24], rsv, sdec(w[31:30]), sdec(w[29:28]), mdec(w[23:20]), mdec(w[19:16]),
                pat, w[7:6], w[7:6] == 2'h3, w[5:4], w[2:0]};
    endfunction : dec

    // Monitor: every launch consumes the oldest expected decode
    always @(negedge i_clock) begin
        if (o_op_start === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(32'(obs), 32'(exp_q.pop_front()));
        end
    end

    // Running operation: pattern, refused write, then completion
    task automatic finish_op(input logic [31:0] w);
        logic pb;
        check(32'(o_busy), 32'h1);
        i_src_pixel = 8'($urandom);
        i_pat_map_bit = 1'($urandom);
        #1;
        pb = (w[15:12] == 4'h8) ? 1'b1 : (w[15:12] == 4'h9) ? |i_src_pixel : i_pat_map_bit;
        check(32'(o_pattern_bit), 32'(pb));
        check(32'(o_use_foreground), 32'(pb));
        pxop_host_model_inst.wr(`PXOP_OFF_CONTROL, 4'hF, ~w);
        check(32'(o_wr_refused), 32'h1);
        check(32'(obs), 32'(dec(w)));
        @(posedge i_clock);
        #1 i_op_done = 1'b1;
        @(posedge i_clock);
        #1 i_op_done = 1'b0;
        check(32'(o_busy), 32'h0);
    endtask : finish_op

    // Draw-and-step codes wait for the direction steps write
    task automatic run_op(input logic [31:0] w, input int mode);
        shadow = w;
        if (!(w[27:24] inside {4'h2, 4'h4})) exp_q.push_back(dec(w));
        pxop_host_model_inst.load(w, mode);
        if (w[27:24] inside {4'h2, 4'h4}) begin
            check(32'(o_busy), 32'h0);
            exp_q.push_back(dec(w));
            pxop_host_model_inst.wr(`PXOP_OFF_DIR_STEPS, 4'hF, $urandom);
        end
        finish_op(w);
    endtask : run_op

    initial begin
        logic [31:0] w;
        i_nrst = 1'b0;
        i_op_done = 1'b0;
        i_pat_map_bit = 1'b0;
        i_src_pixel = 8'h00;
        void'($urandom(14));
        repeat (20) @(posedge i_clock);
        #1 i_nrst = 1'b1;
        check(32'(o_func), 32'h8);
        check(32'(o_busy), 32'h0);
        // Every function code in each of the three write styles
        for (int i = 0; i < 48; i++) begin
            w = $urandom;
            w[27:24] = i[3:0];
            w[15:12] = (i % 3 == 0) ? 4'h8 : (i % 3 == 1) ? 4'h9 : w[15:12];
            run_op(w, i / 16);
        end
        $display("Test sweep done");
        // Unmapped write ignored, single-lane merge into held word
        w = $urandom;
        w[27:24] = 4'h8;
        exp_q.push_back(dec({w[31:24], shadow[23:8], w[7:0]}));
        pxop_host_model_inst.wr(7'h40, 4'hF, ~w);
        pxop_host_model_inst.wr(`PXOP_OFF_CONTROL, 4'h1, w);
        pxop_host_model_inst.wr(`PXOP_OFF_CONTROL, 4'h8, w);
        finish_op({w[31:24], shadow[23:8], w[7:0]});
        $display("Test merge done");
        // Reset while idle after the last completion, then one more operation
        #1 i_nrst = 1'b0;
        repeat (2) @(posedge i_clock);
        check(32'(o_func), 32'h8);
        #1 i_nrst = 1'b1;
        run_op(32'h08121000, 0);
        $display("Test second reset done");
        end_sim;
    end

    // Watchdog: the run needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        miscompares++;
        end_sim;
    end
endmodule : tb_top
